// ==== fault_env_model.sv ====
// Far side model: fault pin, comparator, waveform source and timer tick.
// Assumes the bench calls its tasks from procedures timed on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module fault_env_model (
  input  wire logic       ref_clk,
  output logic            ext_fault_pin,
  output logic            comparator_out,
  output logic [7:0]      waveform_in,
  output logic            timer_tick
);
  initial begin
    ext_fault_pin = 1'b0;
    comparator_out = 1'b0;
    waveform_in = 8'h00;
    timer_tick = 1'b0;
  end
  // Fault pin and comparator levels come only from this model; software writes to the port never reach them.
  task automatic drive(input logic pin, input logic cmp);
    @(posedge ref_clk);
    ext_fault_pin <= pin;
    comparator_out <= cmp;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    timer_tick <= 1'b1;
    @(posedge ref_clk);
    timer_tick <= 1'b0;
  endtask
  task automatic wave(input logic [7:0] w);
    @(posedge ref_clk);
    waveform_in <= w;
  endtask
endmodule
`default_nettype wire

// ==== fault_guard_asserts.sv ====
// Bus handshake and interrupt checks for the fault guard block, bound to its ports.
// Assumes a master that offers write address and write data together.
`timescale 1ns/100ps
`default_nettype none
module fault_guard_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        fault_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic irq_en_ff;
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_ctrl_wr;
    s_wr_both ##0 (s_axi_awaddr == fault_guard_pkg::OFS_FAULT_CTRL);
  endsequence
  // Shadow of the interrupt enable, so the interrupt can be tied to its cause.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_en_ff <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                 s_axi_awaddr == fault_guard_pkg::OFS_FAULT_CTRL) begin
      irq_en_ff <= s_axi_wdata[fault_guard_pkg::FCTRL_IRQ_EN_BIT];
    end
  end
  a_wr_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_bv_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("second write response");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read data late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read address open while busy");
  a_rd_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("read data above byte");
  a_unmapped_err: assert property (s_rd_take ##0 (s_axi_araddr > fault_guard_pkg::OFS_PORT_B) |=>
    s_axi_rresp == fault_guard_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_irq_needs_en: assert property (fault_irq |-> irq_en_ff || $past(irq_en_ff, 2)) else $error("interrupt while disabled");
  a_irq_cleared: assert property (s_ctrl_wr ##0 (s_axi_wdata[2:1] == 2'b10) |-> ##[1:4] !fault_irq)
    else $error("interrupt stays after clear");
endmodule
bind timer_fault_guard_wide_access fault_guard_asserts u_chk (
  .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .fault_irq(fault_irq));
`default_nettype wire

// ==== fault_guard_pkg.sv ====
// Constants shared by the fault guard and wide access block and its input conditioner.
// Assumes an AXI4-Lite master on the register side; all offsets are byte addresses.
package fault_guard_pkg;
  localparam int WIDE_W      = 10;
  localparam int HIGH_W      = 2;
  localparam int NUM_WIDE    = 5;
  localparam int NUM_CH      = 4;
  localparam int SYNC_STAGES = 3;
  localparam int FILT_DEPTH  = 4;
  localparam int ADDR_W      = 8;

  localparam logic [7:0] OFS_CONTROL_D   = 8'h00;
  localparam logic [7:0] OFS_FAULT_CTRL  = 8'h04;
  localparam logic [7:0] OFS_COMPARE_OUT = 8'h08;
  localparam logic [7:0] OFS_SHARED_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TIMER_COUNT = 8'h10;
  localparam logic [7:0] OFS_COMPARE_A   = 8'h14;
  localparam logic [7:0] OFS_COMPARE_B   = 8'h18;
  localparam logic [7:0] OFS_COMPARE_C   = 8'h1c;
  localparam logic [7:0] OFS_COMPARE_D   = 8'h20;
  localparam logic [7:0] OFS_PORT_B      = 8'h24;

  localparam int CTLD_FILTER_EN_BIT  = 0;
  localparam int CTLD_SRC_CMP_BIT    = 1;
  localparam int FCTRL_GUARD_EN_BIT  = 0;
  localparam int FCTRL_IRQ_EN_BIT    = 1;
  localparam int FCTRL_FLAG_BIT      = 2;

  localparam logic [2:0] SLOT_COUNT = 3'h0;
  localparam logic [2:0] SLOT_CMP_A = 3'h1;
  localparam logic [2:0] SLOT_CMP_B = 3'h2;
  localparam logic [2:0] SLOT_CMP_C = 3'h3;
  localparam logic [2:0] SLOT_CMP_D = 3'h4;
  localparam logic [2:0] SLOT_NONE  = 3'h7;

  localparam logic [7:0] RST_COMPARE_OUT = 8'h00;
  localparam logic [7:0] RST_PORT_B      = 8'h00;
  localparam logic [1:0] RST_SHARED_HIGH = 2'h0;
  localparam logic [9:0] RST_WIDE        = 10'h000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== fault_input_cond.sv ====
// Synchroniser, optional four-deep noise filter for one fault trigger input.
// Assumes raw_in is asynchronous to ref_clk; filter_en comes from ref_clk logic.
`timescale 1ns/100ps
`default_nettype none
module fault_input_cond (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic raw_in,
  input  wire logic filter_en,
  output logic      level_out
);
  typedef struct packed {
    logic [fault_guard_pkg::SYNC_STAGES-1:0] sync;
    logic                                    stable;
    logic [fault_guard_pkg::FILT_DEPTH-1:0]  pipe;
    logic                                    filt;
    logic                                    level;
  } cond_t;

  cond_t s_ff;
  cond_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync = {s_ff.sync[1:0], raw_in};
    // Only the second and third stages are compared; the first is left to settle.
    if (s_ff.sync[1] == s_ff.sync[2]) begin
      nxt_s.stable = s_ff.sync[2];
    end
    nxt_s.pipe = {s_ff.pipe[fault_guard_pkg::FILT_DEPTH-2:0], s_ff.stable};
    if ((&s_ff.pipe) || (~|s_ff.pipe)) begin
      nxt_s.filt = s_ff.pipe[fault_guard_pkg::FILT_DEPTH-1];
    end
    nxt_s.level = filter_en ? s_ff.filt : s_ff.stable;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign level_out = s_ff.level;
endmodule
`default_nettype wire

// ==== test_timer_fault_guard_wide_access.sv ====
// Self-checking bench for the fault guard and byte-wide access block.
// Assumes the checker is bound by its own file and the far side model drives fault inputs.
`timescale 1ns/100ps
`default_nettype none
module test_timer_fault_guard_wide_access;
  logic        ref_clk, rst, timer_tick, ext_fault_pin, comparator_out, fault_irq;
  logic [7:0]  waveform_in, s_axi_awaddr, s_axi_araddr, pwm_pin_out;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, hi[5];
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  lo[5];
  logic [31:0] exp_q[$];
  logic [1:0]  bresp_q[$], rresp_q[$];
  int          err_count, total_checks, cyc, n1, n2;
  timer_fault_guard_wide_access u_dut (.ref_clk(ref_clk), .rst(rst), .timer_tick(timer_tick),
    .ext_fault_pin(ext_fault_pin), .comparator_out(comparator_out), .waveform_in(waveform_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwm_pin_out(pwm_pin_out),
    .fault_irq(fault_irq));
  fault_env_model u_env (.ref_clk(ref_clk), .ext_fault_pin(ext_fault_pin),
    .comparator_out(comparator_out), .waveform_in(waveform_in), .timer_tick(timer_tick));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Every register sits at or below the port register; anything above it must answer with an error.
  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a > fault_guard_pkg::OFS_PORT_B) ? fault_guard_pkg::RESP_SLVERR : fault_guard_pkg::RESP_OKAY;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bresp_q.push_back(exp_resp(a));
    s_axi_awaddr <= a;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    rresp_q.push_back(exp_resp(a));
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (fault_irq !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, fault_irq}, 32'h1);
  endtask
  // Read results are matched in issue order, whenever the data handshake completes.
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check(s_axi_rdata, exp_q.pop_front());
      check({30'h0, s_axi_rresp}, {30'h0, rresp_q.pop_front()});
    end
    if (s_axi_bvalid && s_axi_bready) check({30'h0, s_axi_bresp}, {30'h0, bresp_q.pop_front()});
  end
  always #2 ref_clk = ~ref_clk;
  // The ceiling sits well above the few hundred cycles the sequence needs.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    rnd = 32'hc6dd;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h0, 8'h0, 32'h0, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      hi[i] = rnd[9:8];
      lo[i] = rnd[7:0];
      wr(8'h0c, {6'h0, hi[i]});
      wr(8'h10 + 8'(4 * i), lo[i]);
    end
    // A stale high value must be replaced by every low byte read.
    wr(8'h0c, {6'h0, ~hi[4]});
    for (int i = 4; i >= 0; i--) begin
      rd(8'h10 + 8'(4 * i), {24'h0, lo[i]});
      rd(8'h0c, {30'h0, hi[i]});
    end
    wr(8'h0c, 8'h02);
    wr(8'h14, 8'h11);
    wr(8'h18, 8'h22);
    rd(8'h18, 32'h22);
    rd(8'h0c, 32'h2);
    rd(8'h14, 32'h11);
    wr(8'h0c, 8'h03);
    wr(8'h10, 8'hff);
    u_env.tick();
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 8'h5a);
    u_env.wave(rnd[15:8]);
    wr(8'h08, 8'hff);
    wr(8'h24, 8'h5a);
    wr(8'h04, 8'h07);
    repeat (4) @(posedge ref_clk);
    check({24'h0, pwm_pin_out}, {24'h0, rnd[15:8]});
    u_env.drive(1'b1, 1'b0);
    wait_irq(n1);
    check({24'h0, pwm_pin_out}, 32'h5a);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h6);
    wr(8'h04, 8'h04);
    rd(8'h04, 32'h0);
    wr(8'h08, 8'h0f);
    u_env.drive(1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    rd(8'h04, 32'h4);
    rd(8'h08, 32'h0f);
    check({24'h0, pwm_pin_out}, {24'h5, rnd[11:8]} | 32'h50);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h07);
    u_env.drive(1'b1, 1'b0);
    repeat (20) @(posedge ref_clk);
    rd(8'h04, 32'h3);
    u_env.drive(1'b1, 1'b1);
    @(posedge ref_clk);
    u_env.drive(1'b1, 1'b0);
    repeat (20) @(posedge ref_clk);
    rd(8'h04, 32'h3);
    u_env.drive(1'b1, 1'b1);
    wait_irq(n2);
    check({31'h0, (n2 - n1 >= 4) && (n2 - n1 <= 5)}, 32'h1);
    rd(8'h04, 32'h6);
    close_out();
  end
endmodule
`default_nettype wire

// ==== timer_fault_guard_wide_access.sv ====
// Fault guard for the PWM pins and byte-wide access to the 10-bit timer registers.
// Assumes an AXI4-Lite master on ref_clk, a waveform generator supplying waveform_in,
// and a timer tick pulse from a prescaler on the same clock.
`timescale 1ns/100ps
`default_nettype none
module timer_fault_guard_wide_access (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        timer_tick,
  input  wire logic        ext_fault_pin,
  input  wire logic        comparator_out,
  input  wire logic [7:0]  waveform_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       pwm_pin_out,
  output logic             fault_irq
);
  typedef struct packed {
    logic                                     aw_got;
    logic [fault_guard_pkg::ADDR_W-1:0]       waddr;
    logic                                     w_got;
    logic [7:0]                               wbyte;
    logic                                     wlane;
    logic                                     awready;
    logic                                     wready;
    logic                                     bvalid;
    logic [1:0]                               bresp;
    logic                                     arready;
    logic                                     rvalid;
    logic [31:0]                              rdata;
    logic [1:0]                               rresp;
    logic                                     filter_en;
    logic                                     src_cmp;
    logic                                     guard_en;
    logic                                     irq_en;
    logic                                     flag;
    logic [7:0]                               com_mode;
    logic [fault_guard_pkg::HIGH_W-1:0]       high;
    logic [fault_guard_pkg::NUM_WIDE-1:0][fault_guard_pkg::WIDE_W-1:0] wide;
    logic [7:0]                               port_b;
    logic                                     sel_prev;
    logic [7:0]                               pins;
    logic                                     irq;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic [1:0] src_level;

  // Maps a byte address to the slot of a 10-bit register, or to no slot.
  function automatic logic [2:0] wide_slot(input logic [7:0] a);
    case (a)
      fault_guard_pkg::OFS_TIMER_COUNT: wide_slot = fault_guard_pkg::SLOT_COUNT;
      fault_guard_pkg::OFS_COMPARE_A:   wide_slot = fault_guard_pkg::SLOT_CMP_A;
      fault_guard_pkg::OFS_COMPARE_B:   wide_slot = fault_guard_pkg::SLOT_CMP_B;
      fault_guard_pkg::OFS_COMPARE_C:   wide_slot = fault_guard_pkg::SLOT_CMP_C;
      fault_guard_pkg::OFS_COMPARE_D:   wide_slot = fault_guard_pkg::SLOT_CMP_D;
      default:                          wide_slot = fault_guard_pkg::SLOT_NONE;
    endcase
  endfunction

  // Register kinds behind the byte addresses; both bus paths decode through one function.
  // Decoding once keeps the read map and the write map from drifting apart.
  typedef enum {
    kind_ctrl_d,
    kind_fault_ctrl,
    kind_compare_out,
    kind_shared_high,
    kind_port_b,
    kind_wide,
    kind_none
  } reg_kind_t;

  // Addresses that name no register answer with an error and change nothing.
  function automatic reg_kind_t reg_kind(input logic [7:0] a);
    case (a)
      fault_guard_pkg::OFS_CONTROL_D:   reg_kind = kind_ctrl_d;
      fault_guard_pkg::OFS_FAULT_CTRL:  reg_kind = kind_fault_ctrl;
      fault_guard_pkg::OFS_COMPARE_OUT: reg_kind = kind_compare_out;
      fault_guard_pkg::OFS_SHARED_HIGH: reg_kind = kind_shared_high;
      fault_guard_pkg::OFS_PORT_B:      reg_kind = kind_port_b;
      default: begin
        if (wide_slot(a) != fault_guard_pkg::SLOT_NONE) begin
          reg_kind = kind_wide;
        end else begin
          reg_kind = kind_none;
        end
      end
    endcase
  endfunction

  // The pin input is ext_fault_pin alone, so a value software drives through the port is not seen.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_src
      fault_input_cond u_cond (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .raw_in    ((gi == 0) ? ext_fault_pin : comparator_out),
        .filter_en (s_ff.filter_en),
        .level_out (src_level[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [2:0] rslot;
    logic [2:0] wslot;
    logic [7:0] rd;
    logic       rhit;
    logic       whit;
    logic       sel_level;
    logic       trig_edge;
    logic       aw_take;
    logic       w_take;
    logic       ar_take;
    logic       wr_go;
    rslot     = wide_slot(s_axi_araddr);
    wslot     = wide_slot(s_ff.waddr);
    rd        = 8'h00;
    rhit      = 1'b1;
    whit      = 1'b1;
    sel_level = 1'b0;
    trig_edge = 1'b0;
    // Ready flags are registered, so each transfer is taken on the edge where valid meets them.
    aw_take   = s_axi_awvalid && s_ff.awready;
    w_take    = s_axi_wvalid && s_ff.wready;
    ar_take   = s_axi_arvalid && s_ff.arready;
    wr_go     = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    nxt_s     = s_ff;

    // The count advances only on enabled edges of the one system clock.
    // A low byte write to the count is applied further down, so it wins over a same-cycle tick.
    if (timer_tick) begin
      nxt_s.wide[fault_guard_pkg::SLOT_COUNT] = s_ff.wide[fault_guard_pkg::SLOT_COUNT] + 10'h001;
    end

    if (aw_take) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.waddr  = s_axi_awaddr;
    end
    if (w_take) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wbyte = s_axi_wdata[7:0];
      nxt_s.wlane = s_axi_wstrb[0];
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end

    // Read channel; a low byte read also latches the upper bits.
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid  = 1'b0;
      nxt_s.arready = 1'b1;
    end
    if (ar_take) begin
      case (reg_kind(s_axi_araddr))
        kind_ctrl_d: begin
          rd[fault_guard_pkg::CTLD_FILTER_EN_BIT] = s_ff.filter_en;
          rd[fault_guard_pkg::CTLD_SRC_CMP_BIT]   = s_ff.src_cmp;
        end
        kind_fault_ctrl: begin
          rd[fault_guard_pkg::FCTRL_GUARD_EN_BIT] = s_ff.guard_en;
          rd[fault_guard_pkg::FCTRL_IRQ_EN_BIT]   = s_ff.irq_en;
          rd[fault_guard_pkg::FCTRL_FLAG_BIT]     = s_ff.flag;
        end
        kind_compare_out: rd = s_ff.com_mode;
        kind_shared_high: rd = {6'h00, s_ff.high};
        kind_port_b:      rd = s_ff.port_b;
        kind_wide: begin
          rd         = s_ff.wide[rslot][7:0];
          nxt_s.high = s_ff.wide[rslot][9:8];
        end
        default: begin
          rhit = 1'b0;
        end
      endcase
      nxt_s.rdata   = {24'h000000, rd};
      nxt_s.rresp   = rhit ? fault_guard_pkg::RESP_OKAY : fault_guard_pkg::RESP_SLVERR;
      nxt_s.rvalid  = 1'b1;
      nxt_s.arready = 1'b0;
    end

    // A write completes once address and data are both held and no response waits.
    // It is applied after the read path, so a write of the shared bits beats a same-cycle copy.
    if (wr_go) begin
      case (reg_kind(s_ff.waddr))
        kind_ctrl_d: begin
          if (s_ff.wlane) begin
            nxt_s.filter_en = s_ff.wbyte[fault_guard_pkg::CTLD_FILTER_EN_BIT];
            nxt_s.src_cmp   = s_ff.wbyte[fault_guard_pkg::CTLD_SRC_CMP_BIT];
          end
        end
        kind_fault_ctrl: begin
          if (s_ff.wlane) begin
            nxt_s.guard_en = s_ff.wbyte[fault_guard_pkg::FCTRL_GUARD_EN_BIT];
            nxt_s.irq_en   = s_ff.wbyte[fault_guard_pkg::FCTRL_IRQ_EN_BIT];
            if (s_ff.wbyte[fault_guard_pkg::FCTRL_FLAG_BIT]) begin
              nxt_s.flag = 1'b0;
            end
          end
        end
        kind_compare_out: begin
          if (s_ff.wlane) begin
            nxt_s.com_mode = s_ff.wbyte;
          end
        end
        kind_shared_high: begin
          if (s_ff.wlane) begin
            nxt_s.high = s_ff.wbyte[1:0];
          end
        end
        kind_port_b: begin
          if (s_ff.wlane) begin
            nxt_s.port_b = s_ff.wbyte;
          end
        end
        kind_wide: begin
          if (s_ff.wlane) begin
            nxt_s.wide[wslot] = {s_ff.high, s_ff.wbyte};
          end
        end
        default: begin
          whit = 1'b0;
        end
      endcase
      nxt_s.bresp  = whit ? fault_guard_pkg::RESP_OKAY : fault_guard_pkg::RESP_SLVERR;
      nxt_s.bvalid = 1'b1;
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
    end
    nxt_s.awready = ~nxt_s.aw_got;
    nxt_s.wready  = ~nxt_s.w_got;

    // Switching the source can itself show up as an edge, which is why software clears the flag.
    sel_level      = s_ff.src_cmp ? src_level[1] : src_level[0];
    nxt_s.sel_prev = sel_level;
    trig_edge      = sel_level ^ s_ff.sel_prev;

    // Hardware events are applied after software writes so the flag set and guard clears win over a same-cycle write.
    if (trig_edge) begin
      nxt_s.flag = 1'b1;
      if (s_ff.guard_en) begin
        nxt_s.com_mode = 8'h00;
        nxt_s.guard_en = 1'b0;
      end
    end
    nxt_s.irq = s_ff.flag & s_ff.irq_en;

    // Any nonzero mode connects the waveform pair; a cleared mode hands pins to the port.
    for (int ch = 0; ch < fault_guard_pkg::NUM_CH; ch++) begin
      if (|nxt_s.com_mode[2*ch +: 2]) begin
        nxt_s.pins[2*ch +: 2] = waveform_in[2*ch +: 2];
      end else begin
        nxt_s.pins[2*ch +: 2] = nxt_s.port_b[2*ch +: 2];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_ff          <= '0;
      s_ff.awready  <= 1'b1;
      s_ff.wready   <= 1'b1;
      s_ff.arready  <= 1'b1;
      s_ff.com_mode <= fault_guard_pkg::RST_COMPARE_OUT;
      s_ff.port_b   <= fault_guard_pkg::RST_PORT_B;
      s_ff.high     <= fault_guard_pkg::RST_SHARED_HIGH;
      s_ff.wide     <= {fault_guard_pkg::NUM_WIDE{fault_guard_pkg::RST_WIDE}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready  = s_ff.wready;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign pwm_pin_out   = s_ff.pins;
  assign fault_irq     = s_ff.irq;
endmodule
`default_nettype wire
